//--- design/fre_control.sv
// file: flash row erase sequencer with apb register slave
`timescale 1ns/100ps
// Summary of operation
// - erase acts on whole rows only, never single words or wider regions
// - any address within the row selects that entire row for erase
// - consecutive unlock writes 55h then aah arm the next start
// - setting write-start with erase select begins the row erase
// - two instruction cycles of setup follow the start before the stall
// - instruction execution halts for the timed erase, typically 2 ms
// - clocks and peripherals keep running during the erase stall
// - execution resumes at the third instruction after the start write
module fre_control
  import fre_pkg::*;
#(
  parameter int ERASE_COUNT = ERASE_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output logic                       cpu_stall,
  output logic                       periph_run,
  output logic                       erase_strobe,
  output logic      [ADDR_WIDTH-1:0] erase_row_addr
);
  localparam int CW = $clog2(ERASE_COUNT + 1) + 1;

  initial begin
    if (ERASE_COUNT < 2) $error("fre_control: ERASE_COUNT must be at least 2");
  end

  // ==========================================================================
  // bus decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction : hit

  logic wr_acc;
  logic mapped;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = hit(paddr, ADDR_ADDR_LOW) || hit(paddr, ADDR_ADDR_HIGH)
               || hit(paddr, ADDR_CONTROL) || hit(paddr, ADDR_UNLOCK)
               || hit(paddr, ADDR_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================================
  // registers
  logic [7:0]            addr_low_r;
  logic [6:0]            addr_high_r;
  logic                  cfg_sel_r;
  logic                  latch_only_r;
  logic                  erase_sel_r;
  logic                  allow_r;
  logic                  err_r;
  logic                  wr_start_r;
  logic [1:0]            unlock_r;
  logic [1:0]            setup_cnt_r;
  logic [ADDR_WIDTH-1:0] row_r;
  fre_state_t            state_r;
  fre_state_t            state_nxt;
  logic                  timer_done;
  logic                  ctl_wr;
  logic                  start_req;
  logic                  start_ok;

  assign ctl_wr    = wr_acc && hit(paddr, ADDR_CONTROL);
  assign start_req = ctl_wr && pwdata[BIT_WRITE_START] && !wr_start_r;
  // accepted only when enabled, unlocked and erase selected; else flagged
  assign start_ok  = start_req && allow_r && pwdata[BIT_ALLOW]
                  && (unlock_r == 2'd2) && pwdata[BIT_ERASE_SELECT];

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_low_r  <= 8'h00;
      addr_high_r <= 7'h00;
    end else if (wr_acc && hit(paddr, ADDR_ADDR_LOW)) begin
      addr_low_r <= pwdata[7:0];
    end else if (wr_acc && hit(paddr, ADDR_ADDR_HIGH)) begin
      addr_high_r <= pwdata[6:0];
    end
  end

  // unlock: 55h then aah as consecutive register writes; any other write disarms
  always_ff @(posedge clk) begin
    if (rst) begin
      unlock_r <= 2'd0;
    end else if (wr_acc && hit(paddr, ADDR_UNLOCK)) begin
      if (pwdata[7:0] == UNLOCK_FIRST) begin
        unlock_r <= 2'd1;
      end else if (pwdata[7:0] == UNLOCK_SECOND && unlock_r == 2'd1) begin
        unlock_r <= 2'd2;
      end else begin
        unlock_r <= 2'd0;
      end
    end else if (wr_acc) begin
      unlock_r <= 2'd0;
    end
  end

  // control fields; software may set but never clear write-start
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_sel_r    <= CONTROL_RESET[BIT_CONFIG_SPACE];
      latch_only_r <= CONTROL_RESET[BIT_LATCH_ONLY];
      erase_sel_r  <= CONTROL_RESET[BIT_ERASE_SELECT];
      allow_r      <= CONTROL_RESET[BIT_ALLOW];
    end else if (ctl_wr && !wr_start_r) begin
      cfg_sel_r    <= pwdata[BIT_CONFIG_SPACE];
      latch_only_r <= pwdata[BIT_LATCH_ONLY];
      allow_r      <= pwdata[BIT_ALLOW];
      erase_sel_r  <= pwdata[BIT_ERASE_SELECT];
    end else if (state_r == FRE_DONE) begin
      erase_sel_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_start_r <= 1'b0;
    end else if (state_r == FRE_DONE) begin
      wr_start_r <= 1'b0;
    end else if (start_ok) begin
      wr_start_r <= 1'b1;
    end
  end

  // error: set wins over a software clear in the same write
  always_ff @(posedge clk) begin
    if (rst) begin
      err_r <= 1'b0;
    end else if (start_req && !start_ok) begin
      err_r <= 1'b1;
    end else if (ctl_wr && !pwdata[BIT_SEQ_ERROR]) begin
      err_r <= 1'b0;
    end
  end

  // ==========================================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FRE_IDLE:  if (start_ok) state_nxt = FRE_SETUP;
      FRE_SETUP: if (setup_cnt_r == 2'(SETUP_CYCLES - 1)) state_nxt = FRE_ERASE;
      FRE_ERASE: if (timer_done) state_nxt = FRE_DONE;
      FRE_DONE:  state_nxt = FRE_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= FRE_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      setup_cnt_r <= 2'd0;
    end else if (state_r == FRE_SETUP) begin
      setup_cnt_r <= setup_cnt_r + 2'd1;
    end else begin
      setup_cnt_r <= 2'd0;
    end
  end

  // row base latched at start: low word bits dropped so any word picks its row
  always_ff @(posedge clk) begin
    if (rst) begin
      row_r <= '0;
    end else if (start_ok) begin
      row_r <= {addr_high_r, addr_low_r[7:ROW_WORDS_LOG2], {ROW_WORDS_LOG2{1'b0}}};
    end
  end

  fre_timer #(
    .COUNT_WIDTH (CW)
  ) u_timer (
    .clk        (clk),
    .rst        (rst),
    .load       (state_r == FRE_SETUP && state_nxt == FRE_ERASE),
    .load_value (CW'(ERASE_COUNT)),
    .expired    (timer_done)
  );

  // stall only the core; the two setup cycles let the no-op slots retire,
  // so fetch resumes at the third instruction after the start write
  assign cpu_stall      = (state_r == FRE_ERASE);
  assign periph_run     = 1'b1;
  assign erase_strobe   = (state_r == FRE_ERASE);
  assign erase_row_addr = row_r;

  // ==========================================================================
  // read data
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_ADDR_LOW:  prdata <= {24'h00_0000, addr_low_r};
        ADDR_ADDR_HIGH: prdata <= {25'h000_0000, addr_high_r};
        ADDR_CONTROL:   prdata <= {24'h00_0000, 1'b1, cfg_sel_r, latch_only_r,
                                   erase_sel_r, err_r, allow_r, wr_start_r, 1'b0};
        ADDR_STATUS:    prdata <= {30'h0000_0000, state_r};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // checks
  // stall length kept in a counter: the default count is far beyond any delay range
  logic [CW-1:0] stall_len_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      stall_len_r <= '0;
    end else if (cpu_stall) begin
      stall_len_r <= stall_len_r + 1'b1;
    end else begin
      stall_len_r <= '0;
    end
  end

  AST_ROW_ALIGN: assert property (@(posedge clk) disable iff (rst)
    erase_row_addr[ROW_WORDS_LOG2-1:0] == '0)
    else $error("row address not aligned");
  AST_SETUP_TWO: assert property (@(posedge clk) disable iff (rst)
    start_ok |=> !cpu_stall ##1 !cpu_stall ##1 cpu_stall)
    else $error("stall not after two setup cycles");
  AST_BAD_START: assert property (@(posedge clk) disable iff (rst)
    (start_req && !start_ok) |=> err_r && state_r == FRE_IDLE)
    else $error("bad start not flagged");
  AST_HW_CLEAR: assert property (@(posedge clk) disable iff (rst)
    $fell(cpu_stall) |=> !wr_start_r)
    else $error("write-start not cleared");
  AST_START_HELD: assert property (@(posedge clk) disable iff (rst)
    (wr_start_r && state_r != FRE_DONE) |=> wr_start_r)
    else $error("write-start dropped early");
  AST_UNLOCK_NEED: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && hit(paddr, ADDR_UNLOCK) && unlock_r != 2'd1) |=> unlock_r != 2'd2)
    else $error("unlock armed without first byte");
  AST_PERIPH: assert property (@(posedge clk) disable iff (rst)
    cpu_stall |-> periph_run)
    else $error("peripherals stopped");
  AST_STALL_END: assert property (@(posedge clk) disable iff (rst)
    cpu_stall |-> stall_len_r < CW'(ERASE_COUNT))
    else $error("stall did not end");
  COV_ERASE: cover property (@(posedge clk) disable iff (rst) $fell(cpu_stall));
  COV_ERR:   cover property (@(posedge clk) disable iff (rst) start_req && !start_ok);
  COV_UNLK:  cover property (@(posedge clk) disable iff (rst) unlock_r == 2'd2);
endmodule : fre_control

//--- design/fre_pkg.sv
// package: register map, field positions and timing for the flash row erase control
package fre_pkg;
  // ==========================================================================
  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_ADDR_LOW  = 8'h00;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CONTROL   = 8'h08;
  localparam logic [7:0] ADDR_UNLOCK    = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  // ==========================================================================
  // control register fields
  localparam int BIT_READ_START   = 0;
  localparam int BIT_WRITE_START  = 1;
  localparam int BIT_ALLOW        = 2;
  localparam int BIT_SEQ_ERROR    = 3;
  localparam int BIT_ERASE_SELECT = 4;
  localparam int BIT_LATCH_ONLY   = 5;
  localparam int BIT_CONFIG_SPACE = 6;
  localparam int BIT_UNIMPL       = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // ==========================================================================
  // unlock pair and timing
  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;
  localparam int SETUP_CYCLES   = 2;
  localparam int ERASE_TIME_US  = 2000;
  localparam int CLK_MHZ        = 25;
  localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
  localparam int ADDR_WIDTH     = 15;
  localparam int ROW_WORDS_LOG2 = 5;
  // ==========================================================================
  // sequencer states
  typedef enum logic [1:0] {
    FRE_IDLE  = 2'b00,
    FRE_SETUP = 2'b01,
    FRE_ERASE = 2'b10,
    FRE_DONE  = 2'b11
  } fre_state_t;
endpackage : fre_pkg

//--- design/fre_timer.sv
// file: down counter that times the self-timed erase period
`timescale 1ns/100ps
module fre_timer
  import fre_pkg::*;
#(
  parameter int COUNT_WIDTH = 24
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   load,
  input  wire logic [COUNT_WIDTH-1:0] load_value,
  output logic                        expired
);
  logic [COUNT_WIDTH-1:0] count_r;

  initial begin
    if (COUNT_WIDTH < 2) $error("fre_timer: COUNT_WIDTH too small");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= load_value;
    end else if (count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  // expiry is a pulse on the last count so the caller sees it once
  assign expired = (count_r == {{(COUNT_WIDTH-1){1'b0}}, 1'b1});
endmodule : fre_timer

//--- verification/tb_flash_row_erase_control.sv
// testbench: apb-driven checks of the flash row erase sequencer
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_flash_row_erase_control;
  import fre_pkg::*;
  // ==========================================================================
  // setup
  // short erase count keeps the run small; the stall length check and the wait loop bounds derive from it
  localparam int EC = 20;
  logic                  clk     = 1'b0;
  logic                  rst     = 1'b1;
  logic                  psel    = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite  = 1'b0;
  logic [7:0]            paddr   = 8'h00;
  logic [31:0]           pwdata  = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  cpu_stall;
  logic                  periph_run;
  logic                  erase_strobe;
  logic [ADDR_WIDTH-1:0] erase_row_addr;
  logic [31:0]           rd;
  logic                  err;
  int                    mismatches = 0;
  int                    n_checks   = 0;
  int                    n;
  always #20 clk = ~clk;
  fre_control #(.ERASE_COUNT(EC)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_stall(cpu_stall), .periph_run(periph_run),
    .erase_strobe(erase_strobe), .erase_row_addr(erase_row_addr)
  );
  // ==========================================================================
  // bus tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  // unlock may be skipped or broken by a stray write between the two halves
  task automatic arm_start(input bit unlock, input bit disarm, input logic [7:0] ctl);
    wr(ADDR_CONTROL, 8'h14);
    if (unlock) begin
      wr(ADDR_UNLOCK, UNLOCK_FIRST);
      if (disarm) wr(ADDR_ADDR_LOW, 8'h00);
      wr(ADDR_UNLOCK, UNLOCK_SECOND);
    end
    wr(ADDR_CONTROL, ctl);
  endtask : arm_start
  task automatic erase(input logic [7:0] low, input bit probe);
    wr(ADDR_ADDR_LOW, low);
    wr(ADDR_ADDR_HIGH, 8'h12);
    arm_start(1'b1, 1'b0, 8'h16);
    // the two setup slots stand in for the no-ops software must place
    @(posedge clk); #1; `CHK(cpu_stall, 1'b0)
    @(posedge clk); #1; `CHK(cpu_stall, 1'b1)
    `CHK(erase_row_addr, 15'h1220)
    if (probe) begin
      wr(ADDR_CONTROL, 8'h14);
      apb(1'b0, ADDR_CONTROL, 32'h0); `CHK(rd, 32'h96)
      apb(1'b0, ADDR_STATUS, 32'h0); `CHK(rd, 32'h2)
      `CHK(periph_run, 1'b1)
    end else begin
      n = 1;
      while (n < 4 * EC) begin
        @(posedge clk); #1;
        `CHK(periph_run, 1'b1)
        `CHK(erase_strobe, cpu_stall)
        if (cpu_stall !== 1'b1) break;
        n++;
      end
      // the timer is loaded with the full count, so the stall lasts exactly that many cycles
      `CHK(n, EC)
    end
    n = 0;
    while (cpu_stall === 1'b1 && n < 4 * EC) begin
      @(posedge clk); #1;
      n++;
    end
    repeat (2) @(posedge clk);
    // erase select and write-start both clear by hardware at completion
    apb(1'b0, ADDR_CONTROL, 32'h0); `CHK(rd, 32'h84)
    apb(1'b0, ADDR_STATUS, 32'h0); `CHK(rd, 32'h0)
  endtask : erase
  task automatic bad_start(input bit unlock, input bit disarm, input logic [7:0] ctl);
    arm_start(unlock, disarm, ctl);
    repeat (3) @(posedge clk); #1;
    `CHK(cpu_stall, 1'b0)
    apb(1'b0, ADDR_CONTROL, 32'h0); `CHK(rd[BIT_SEQ_ERROR], 1'b1)
    wr(ADDR_CONTROL, 8'h00);
    apb(1'b0, ADDR_CONTROL, 32'h0); `CHK(rd[BIT_SEQ_ERROR], 1'b0)
  endtask : bad_start
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // ==========================================================================
  // sequence
  initial begin
    #(40 * 4000);
    mismatches++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_CONTROL, 32'h0); `CHK(rd, 32'h80)
    apb(1'b0, ADDR_ADDR_LOW, 32'h0); `CHK(rd, 32'h0)
    apb(1'b0, ADDR_STATUS, 32'h0); `CHK(rd, 32'h0)
    apb(1'b0, 8'h20, 32'h0); `CHK({err, rd}, {1'b1, 32'h0})
    `CHK(cpu_stall, 1'b0)
    erase(8'h37, 1'b0);
    erase(8'h3f, 1'b1);
    bad_start(1'b0, 1'b0, 8'h16);
    bad_start(1'b1, 1'b1, 8'h16);
    bad_start(1'b1, 1'b0, 8'h12);
    erase(8'h20, 1'b0);
    final_report();
  end
endmodule : tb_flash_row_erase_control
